/* dv/hecs_assertions.sv */
// Port checker for the hash engine register slice
`timescale 1ns/1ps
`default_nettype none
module hecs_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        eng_busy,
  input wire logic        eng_ctx_saved,
  input wire logic        dma_data_req,
  input wire logic        dma_ctx_req,
  input wire logic        context_switch_request,
  input wire logic        ctx_save_start,
  input wire logic        main_irq_out,
  input wire logic        partial_digest_irq_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_no_new_data: assert property (context_switch_request && !dma_data_req |=> !dma_data_req)
    else $error("data request rose during switch");
  a_no_new_ctx: assert property (context_switch_request && !dma_ctx_req |=> !dma_ctx_req)
    else $error("context request rose during switch");
  a_save_drained: assert property (ctx_save_start |->
    context_switch_request && !dma_data_req && !dma_ctx_req && !eng_busy)
    else $error("save started before drain");
  a_save_pulse: assert property (ctx_save_start |=> !ctx_save_start)
    else $error("save start longer than one cycle");
  a_switch_done: assert property ($fell(context_switch_request) |->
    $past(eng_ctx_saved) || $past(eng_ctx_saved, 2))
    else $error("switch ended without saved context");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[0:2] s_axi_rvalid)
    else $error("read response late");
  cover property ($rose(ctx_save_start));
  cover property ($rose(partial_digest_irq_out));
  cover property ($rose(main_irq_out));
endmodule
bind hecs_top hecs_checker hecs_checker_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .eng_busy, .eng_ctx_saved, .dma_data_req,
  .dma_ctx_req, .context_switch_request, .ctx_save_start, .main_irq_out,
  .partial_digest_irq_out);
`default_nettype wire

/* dv/hecs_engine_model.sv */
// Engine and DMA partner that answers requests with a variable delay
`timescale 1ns/1ps
`default_nettype none
module hecs_engine_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] lat,
  input  wire logic       dma_data_req,
  input  wire logic       dma_ctx_req,
  input  wire logic       switching,
  input  wire logic       ctx_save_start,
  output logic            eng_data_req,
  output logic            eng_ctx_req,
  output logic            eng_dma_ack,
  output logic            eng_busy,
  output logic            eng_ctx_saved
);
  logic [1:0] cnt;
  always @(posedge aclk) begin
    if (!aresetn) begin
      {eng_data_req, eng_ctx_req, eng_busy} <= 3'h7;
      {eng_dma_ack, eng_ctx_saved} <= 2'h0;
      cnt <= 2'h0;
    end else begin
      eng_dma_ack <= 1'b0;
      eng_ctx_saved <= ctx_save_start;
      // Busy holds until every pending transfer of a switch is done
      eng_busy <= !switching || eng_data_req || eng_ctx_req;
      if ((dma_data_req || dma_ctx_req) && !eng_dma_ack) begin
        cnt <= cnt + 2'h1;
        if (cnt == lat) begin
          eng_dma_ack <= 1'b1;
          cnt <= 2'h0;
          if (switching) {eng_data_req, eng_ctx_req} <= 2'h0;
        end
      end
      // During a switch the engine empties its queue once no transfer is outstanding
      if (switching && !dma_data_req && !dma_ctx_req) {eng_data_req, eng_ctx_req} <= 2'h0;
      if (!switching) {eng_data_req, eng_ctx_req} <= 2'h3;
    end
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the hash engine register slice
`timescale 1ns/1ps
`default_nettype none
`include "hecs_defines.vh"
module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd;
  logic [1:0]  bresp, rresp, lat;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, slot, inacc, resav, fin;
  logic        dreq, creq, ack, busy, saved, ddma, cdma, sw, sst, mirq, pirq;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          err_total, samples_checked, cyc;
  hecs_top hecs_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .eng_ctx_slot_free(slot), .eng_input_accepting(inacc), .eng_result_available(resav),
    .eng_data_req(dreq), .eng_ctx_req(creq), .eng_dma_ack(ack), .eng_busy(busy),
    .eng_final_pass(fin), .eng_ctx_saved(saved), .dma_data_req(ddma), .dma_ctx_req(cdma),
    .context_switch_request(sw), .ctx_save_start(sst), .main_irq_out(mirq),
    .partial_digest_irq_out(pirq));
  hecs_engine_model hecs_engine_model_inst (.aclk(aclk), .aresetn(aresetn), .lat(lat),
    .dma_data_req(ddma), .dma_ctx_req(cdma), .switching(sw), .ctx_save_start(sst),
    .eng_data_req(dreq), .eng_ctx_req(creq), .eng_dma_ack(ack), .eng_busy(busy),
    .eng_ctx_saved(saved));
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom_range(1));
    forever begin
      @(posedge aclk);
      if (bvalid && bready) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge aclk);
    exp_r.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom_range(1));
    forever begin
      @(posedge aclk);
      if (rvalid && rready) break;
      if (arready) arvalid <= 1'b0;
      rready <= 1'b1;
    end
    arvalid <= 1'b0;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] d);
    rd(a, {`HECS_RESP_OKAY, d});
  endtask
  task automatic wc(input logic [11:0] a, input logic [31:0] d);
    wr(a, d, `HECS_RESP_OKAY);
  endtask
  // Outputs settle after registered stages before the look
  task automatic pc(ref logic s, input logic e);
    repeat (3) @(posedge aclk);
    check({33'h0, s}, {33'h0, e});
  endtask
  task automatic wait_sw;
    repeat (3) @(posedge aclk);
    while (sw !== 1'b0) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready) check({rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready) check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      stop_test;
    end
  end
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, inacc, resav, fin} = 9'h0;
    {awaddr, araddr, wdata, lat, slot} = 59'h1;
    wstrb = 4'hF;
    void'($urandom(32'h00EDF6D9));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`HECS_OFF_CONFIG, 32'h0);
    rc(`HECS_OFF_STATUS, 32'h8);
    wr(`HECS_OFF_STATUS, 32'hFFFFFFFF, `HECS_RESP_SLVERR);
    rc(`HECS_OFF_STATUS, 32'h8);
    wr(12'h120, 32'h1, `HECS_RESP_SLVERR);
    rd(12'h120, {`HECS_RESP_SLVERR, 32'h0});
    for (int i = 0; i < 4; i++) begin
      rnd = $urandom;
      slot <= rnd[3];
      inacc <= rnd[1];
      resav <= rnd[0];
      rc(`HECS_OFF_STATUS, {28'h0, rnd[3], 1'b0, rnd[1:0]});
    end
    // Random reserved bits must not stick
    rnd = $urandom & 32'hFFFFFFB3;
    wc(`HECS_OFF_CONFIG, rnd | 32'h0000000C);
    // Lane 0 off: the write must leave the word alone
    wstrb <= 4'hE;
    wc(`HECS_OFF_CONFIG, 32'h0);
    wstrb <= 4'hF;
    rc(`HECS_OFF_CONFIG, 32'h0000000C);
    pc(ddma, 1'b1);
    wc(`HECS_OFF_CONFIG, 32'h4);
    pc(ddma, 1'b0);
    slot <= 1'b0;
    inacc <= 1'b1;
    resav <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wc(`HECS_OFF_CONFIG, (i == 2) ? 32'h0 : 32'h4);
      wc(`HECS_OFF_MASK, (i == 1) ? 32'h1 : 32'h2);
      pc(mirq, i == 0);
    end
    // Switch with engine busy; DMA is enabled by the same write, so no DMA request is pending
    slot <= 1'b1;
    inacc <= 1'b0;
    lat <= 2'($urandom);
    wc(`HECS_OFF_MASK, 32'h0);
    wc(`HECS_OFF_CONFIG, 32'h4C);
    wait_sw;
    rc(`HECS_OFF_STATUS, 32'hC);
    pc(pirq, 1'b1);
    pc(mirq, 1'b0);
    rc(`HECS_OFF_CONFIG, 32'hC);
    wc(`HECS_OFF_CONFIG, 32'h8);
    pc(pirq, 1'b0);
    // Final pass: result flag instead of partial flag
    fin <= 1'b1;
    lat <= 2'($urandom);
    wc(`HECS_OFF_CONFIG, 32'h48);
    wait_sw;
    rc(`HECS_OFF_STATUS, 32'h9);
    repeat (4) @(posedge aclk);
    stop_test;
  end
endmodule
`default_nettype wire

/* hdl/hecs_axil_slave.v */
// AXI4-Lite slave front end for the hash engine register slice
`timescale 1ns/1ps
`default_nettype none
`include "hecs_defines.vh"
module hecs_axil_slave #(
  parameter AW = `HECS_ADDR_W
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  output reg           wr_pulse,
  output reg  [AW-1:0] wr_addr,
  output reg  [31:0]   wr_data,
  output reg  [3:0]    wr_strb,
  input  wire          wr_ok,
  output wire [AW-1:0] rd_addr,
  input  wire [31:0]   rd_data,
  input  wire          rd_ok
);
  reg have_aw;
  reg have_w;
  assign rd_addr = s_axi_araddr;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `HECS_RESP_OKAY;
      have_aw       <= 1'b0;
      have_w        <= 1'b0;
      wr_pulse      <= 1'b0;
      wr_addr       <= {AW{1'b0}};
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `HECS_RESP_OKAY;
    end else begin
      wr_pulse      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      // Address and data taken in either order, one write in flight
      if (s_axi_awvalid && !have_aw && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        have_aw       <= 1'b1;
        wr_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !have_w && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        have_w       <= 1'b1;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end
      if (have_aw && have_w && !wr_pulse && !s_axi_bvalid) begin
        wr_pulse <= 1'b1;
      end
      if (wr_pulse) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `HECS_RESP_OKAY : `HECS_RESP_SLVERR;
        have_aw      <= 1'b0;
        have_w       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_ok ? rd_data : 32'h00000000;
        s_axi_rresp   <= rd_ok ? `HECS_RESP_OKAY : `HECS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/hecs_defines.vh */
// Offsets, field positions, reset values and timing counts of the hash engine register slice
`ifndef HECS_DEFINES_VH
`define HECS_DEFINES_VH
`define HECS_ADDR_W          12
`define HECS_OFF_CONFIG      12'h110
`define HECS_OFF_STATUS      12'h118
`define HECS_OFF_MASK        12'h11C
`define HECS_CFG_DMA_EN      3
`define HECS_CFG_IRQ_EN      2
`define HECS_CFG_CTX_SWT     6
`define HECS_CFG_WMASK       32'h0000004C
`define HECS_ST_CTX_FREE     3
`define HECS_ST_PART_SAVED   2
`define HECS_ST_IN_READY     1
`define HECS_ST_OUT_READY    0
`define HECS_ST_RESET        4'h8
`define HECS_MASK_W          4
`define HECS_SYNC_STAGES     2
`define HECS_RESP_OKAY       2'h0
`define HECS_RESP_SLVERR     2'h2
`endif

/* hdl/hecs_top.v */
// Configuration and status register slice of the hash engine
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hecs_defines.vh"
module hecs_top #(
  parameter AW = `HECS_ADDR_W
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output wire [1:0]    s_axi_bresp,
  output wire          s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output wire [31:0]   s_axi_rdata,
  output wire [1:0]    s_axi_rresp,
  output wire          s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          eng_ctx_slot_free,
  input  wire          eng_input_accepting,
  input  wire          eng_result_available,
  input  wire          eng_data_req,
  input  wire          eng_ctx_req,
  input  wire          eng_dma_ack,
  input  wire          eng_busy,
  input  wire          eng_final_pass,
  input  wire          eng_ctx_saved,
  output reg           dma_data_req,
  output reg           dma_ctx_req,
  output reg           context_switch_request,
  output reg           ctx_save_start,
  output reg           main_irq_out,
  output reg           partial_digest_irq_out
);
  localparam S_IDLE  = 4'b0001;
  localparam S_DRAIN = 4'b0010;
  localparam S_FLUSH = 4'b0100;
  localparam S_SAVE  = 4'b1000;

  wire          wr_pulse;
  wire [AW-1:0] wr_addr;
  wire [31:0]   wr_data;
  wire [3:0]    wr_strb;
  wire [AW-1:0] rd_addr;
  reg  [31:0]   rd_data;
  reg           rd_ok;
  reg           wr_ok;

  reg                     dma_request_enable;
  reg                     global_interrupt_enable;
  reg  [`HECS_MASK_W-1:0] irq_mask;
  reg  [3:0]              status;
  reg                     partial_digest_saved;
  reg                     final_result;
  reg  [3:0]              state;
  reg                     data_pend;
  reg                     ctx_pend;

  function is_reg;
    input [AW-1:0] a;
    begin
      is_reg = (a == `HECS_OFF_CONFIG) || (a == `HECS_OFF_STATUS) ||
               (a == `HECS_OFF_MASK);
    end
  endfunction

  hecs_axil_slave #(.AW(AW)) u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_pulse      (wr_pulse),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // Status word is never a write target
  always @* begin
    wr_ok = is_reg(wr_addr) && (wr_addr != `HECS_OFF_STATUS);
    rd_ok = is_reg(rd_addr);
    rd_data = 32'h00000000;
    case (rd_addr)
      `HECS_OFF_CONFIG: begin
        rd_data[`HECS_CFG_CTX_SWT] = context_switch_request;
        rd_data[`HECS_CFG_DMA_EN]  = dma_request_enable;
        rd_data[`HECS_CFG_IRQ_EN]  = global_interrupt_enable;
      end
      `HECS_OFF_STATUS: rd_data[3:0] = status;
      `HECS_OFF_MASK: rd_data[`HECS_MASK_W-1:0] = irq_mask;
      default: rd_data = 32'h00000000;
    endcase
  end

  wire cfg_wr  = wr_pulse && (wr_addr == `HECS_OFF_CONFIG) && wr_strb[0];
  wire mask_wr = wr_pulse && (wr_addr == `HECS_OFF_MASK) && wr_strb[0];
  wire drained = !data_pend && !ctx_pend;
  wire switch_wr = cfg_wr && wr_data[`HECS_CFG_CTX_SWT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      dma_request_enable      <= 1'b0;
      global_interrupt_enable <= 1'b0;
      context_switch_request  <= 1'b0;
      irq_mask                <= {`HECS_MASK_W{1'b0}};
      state                   <= S_IDLE;
      data_pend               <= 1'b0;
      ctx_pend                <= 1'b0;
      dma_data_req            <= 1'b0;
      dma_ctx_req             <= 1'b0;
      ctx_save_start          <= 1'b0;
      partial_digest_saved    <= 1'b0;
      final_result            <= 1'b0;
      status                  <= `HECS_ST_RESET;
      main_irq_out            <= 1'b0;
      partial_digest_irq_out  <= 1'b0;
    end else begin
      // Only bits 6, 3, 2 are stored; other bits drop
      if (cfg_wr) begin
        dma_request_enable      <= wr_data[`HECS_CFG_DMA_EN];
        global_interrupt_enable <= wr_data[`HECS_CFG_IRQ_EN];
      end
      if (mask_wr) begin
        irq_mask <= wr_data[`HECS_MASK_W-1:0];
      end
      ctx_save_start <= 1'b0;
      case (state)
        S_IDLE: begin
          if (switch_wr) begin
            context_switch_request <= 1'b1;
            partial_digest_saved   <= 1'b0;
            final_result           <= 1'b0;
            state                  <= S_DRAIN;
          end
        end
        S_DRAIN: begin
          if (drained) begin
            state <= S_FLUSH;
          end
        end
        S_FLUSH: begin
          // Saving mid-block would lose buffered data
          if (!eng_busy) begin
            ctx_save_start <= 1'b1;
            final_result   <= eng_final_pass;
            state          <= S_SAVE;
          end
        end
        S_SAVE: begin
          if (eng_ctx_saved) begin
            partial_digest_saved   <= !final_result;
            context_switch_request <= 1'b0;
            state                  <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
      // Pending requests finish; none start while switching
      // Request drops with the ack, so a stale level is never acked twice
      if (eng_dma_ack) begin
        data_pend    <= 1'b0;
        ctx_pend     <= 1'b0;
        dma_data_req <= 1'b0;
        dma_ctx_req  <= 1'b0;
      end else if (dma_request_enable && state == S_IDLE && !switch_wr) begin
        if (eng_data_req) begin
          data_pend    <= 1'b1;
          dma_data_req <= 1'b1;
        end
        if (eng_ctx_req) begin
          ctx_pend    <= 1'b1;
          dma_ctx_req <= 1'b1;
        end
      end
      status[`HECS_ST_CTX_FREE]   <= eng_ctx_slot_free;
      status[`HECS_ST_IN_READY]   <= eng_input_accepting;
      status[`HECS_ST_PART_SAVED] <= partial_digest_saved;
      status[`HECS_ST_OUT_READY]  <= eng_result_available ||
                                     (final_result && state == S_IDLE);
      main_irq_out <= global_interrupt_enable && |(status & irq_mask);
      partial_digest_irq_out <= global_interrupt_enable &&
                                status[`HECS_ST_PART_SAVED];
    end
  end
endmodule
`default_nettype wire
